// ==== src/clock_startup_pkg.sv ====
`default_nettype none

package clock_startup_pkg;

    // Clock source select fuse codes.
    localparam logic [3:0] SRC_PLL = 4'h1;
    localparam logic [3:0] SRC_RC8 = 4'h2;
    localparam logic [3:0] SRC_RC_LEGACY = 4'h3;
    localparam logic [3:0] SRC_LP128K = 4'h4;

    // Start-up time select fuse codes.
    localparam logic [1:0] START_00 = 2'h0;
    localparam logic [1:0] START_01 = 2'h1;
    localparam logic [1:0] START_10 = 2'h2;
    localparam logic [1:0] START_11 = 2'h3;

    // A fuse bit reads zero when it is programmed.
    localparam logic FUSE_PROGRAMMED = 1'b0;

    // Reset values of the latched fuse copies and the calibration register.
    localparam logic [3:0] SRC_RESET = 4'h2;
    localparam logic [1:0] START_RESET = 2'h2;
    localparam logic [7:0] CAL_RESET = 8'h00;

    // Start-up cycle counts, in cycles of the selected source.
    localparam logic [14:0] WAKE_BASE_CK = 15'h000e;
    localparam logic [14:0] SHORT_CK = 15'h0400;
    localparam logic [14:0] RC_WAKE_CK = 15'h0006;
    localparam logic [14:0] FAST_WAKE_CK = 15'h0001;
    localparam logic [14:0] RESET_CK = 15'h000e;

    // Real-time delays in milliseconds and watchdog oscillator ticks per millisecond.
    localparam int MS4_TIME_MS = 4;
    localparam int MS64_TIME_MS = 64;
    localparam int WDT_TICKS_PER_MS = 128;
    localparam logic [13:0] MS4_WDT = 14'(MS4_TIME_MS * WDT_TICKS_PER_MS);

    // Divider ratios used by the tick dividers.
    localparam logic [3:0] RATIO_ONE = 4'h1;
    localparam logic [3:0] RATIO_DIV4 = 4'h4;
    localparam logic [3:0] RATIO_DIV8 = 4'h8;

    // Start-up sequence phases.
    typedef enum logic [2:0] {
        ST_LOAD,
        ST_MS,
        ST_CK,
        ST_RUN,
        ST_SLEEP
    } phase_e;

    // One start-up plan: source cycles and watchdog ticks to wait.
    typedef struct packed {
        logic [14:0] ck;
        logic [13:0] ms;
    } plan_s;

endpackage

`default_nettype wire

// ==== src/tick_divider.sv ====
`default_nettype none

module tick_divider (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic in_tick,
    input wire logic [3:0] ratio,
    output logic out_tick
);
    import clock_startup_pkg::*;

    // All state of the divider.
    typedef struct packed {
        logic [3:0] count;
        logic out;
    } div_s;

    div_s s;
    div_s next_s;

    ////////////////////////////////////////////////////////////////////////////////
    // One output tick for every ratio input ticks; a ratio of one passes ticks through.
    always_comb begin
        next_s = s;
        next_s.out = 1'b0;
        if (in_tick) begin
            // Using >= keeps the divider sane if the ratio shrinks mid-count.
            if (s.count >= ratio - RATIO_ONE) begin
                next_s.count = 4'h0;
                next_s.out = 1'b1;
            end else begin
                next_s.count = s.count + 4'h1;
            end
        end
    end

    // Register the whole state.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_tick = s.out;

endmodule

`default_nettype wire

// ==== src/clock_startup_select.sv ====
`default_nettype none

module clock_startup_select #(
    parameter int LONG_CK = 16384,
    parameter int MS64_WDT = 8192
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] clock_source_select,
    input wire logic [1:0] startup_time_select,
    input wire logic initial_divide_by_eight_fuse,
    input wire logic reset_pin_disable_fuse,
    input wire logic [7:0] factory_calibration,
    input wire logic pll_tick,
    input wire logic rc_tick,
    input wire logic lp_tick,
    input wire logic wdt_tick,
    input wire logic pll_enable_request,
    input wire logic cal_write,
    input wire logic [7:0] cal_write_data,
    input wire logic sleep_request,
    input wire logic wake_request,
    output logic cpu_run,
    output logic sys_clk_tick,
    output logic peripheral_clk_tick,
    output logic wdt_clk_tick,
    output logic pll_enable,
    output logic rc_legacy_mode,
    output logic [7:0] osc_calibration_value,
    output logic config_error
);
    import clock_startup_pkg::*;

    // All state of the block.
    typedef struct packed {
        phase_e phase;
        logic [3:0] cks;
        logic [1:0] stc;
        logic rdis;
        logic div8;
        logic [14:0] ck_left;
        logic [13:0] ms_left;
        logic [7:0] cal;
        logic run;
        logic pll_en;
        logic legacy;
        logic src_tick;
        logic wdt_out;
        logic pck;
        logic cfg_err;
    } state_s;

    state_s st;
    state_s next_st;
    logic div4_tick; // Quarter-rate tick of the PLL or legacy RC clock.
    logic div4_in; // Undivided tick that feeds the quarter-rate divider.
    logic [3:0] prescale_ratio; // Ratio applied to the selected source.

    ////////////////////////////////////////////////////////////////////////////////
    // Works out the wait for a start-up from the fuse values.
    function automatic plan_s startup_plan(
        input logic [3:0] cks,
        input logic [1:0] stc,
        input logic rdis,
        input logic from_rst
    );
        plan_s p;
        logic [14:0] wake_ck;
        logic [14:0] rst_ck;
        logic [13:0] rst_ms;
        begin
            p = '0;
            wake_ck = RC_WAKE_CK;
            rst_ck = RESET_CK;
            rst_ms = 14'h0000;
            case (cks)
                SRC_PLL: begin
                    // Both wake and reset count the cycles; reset adds 4 ms more.
                    wake_ck = WAKE_BASE_CK + (stc[0] ? 15'(LONG_CK) : SHORT_CK);
                    p.ms = stc[1] ? 14'(MS64_WDT) : MS4_WDT;
                    rst_ck = 15'h0000;
                    rst_ms = MS4_WDT;
                end
                SRC_RC_LEGACY: begin
                    // Legacy mode has its own table; code 11 gives the one-cycle wake.
                    case (stc)
                        START_00, START_01: rst_ms = 14'(MS64_WDT);
                        START_10: rst_ms = MS4_WDT;
                        default: begin
                            wake_ck = FAST_WAKE_CK;
                        end
                    endcase
                end
                default: begin
                    // 8 MHz RC, 128 kHz and unsupported codes share one table.
                    // The reserved code 11 runs as 10, the longest and safest wait.
                    case (stc)
                        START_00: rst_ms = 14'h0000;
                        START_01: rst_ms = MS4_WDT;
                        default: rst_ms = 14'(MS64_WDT);
                    endcase
                end
            endcase
            // With the reset pin disabled, a bare 14-cycle reset delay gets 4 ms so programming can still start.
            // Without it a disabled reset pin could leave no window to reprogram.
            if (cks != SRC_PLL && rst_ms == 14'h0000 && rdis == FUSE_PROGRAMMED) begin
                rst_ms = MS4_WDT;
            end
            p.ck = wake_ck;
            if (from_rst) begin
                p.ck = wake_ck + rst_ck;
                p.ms = p.ms + rst_ms;
            end
            startup_plan = p;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Source dividers. The PLL path and the legacy RC path both run at a quarter rate.
    assign div4_in = (st.cks == SRC_PLL) ? pll_tick : rc_tick;

    tick_divider quarter_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_tick(div4_in),
        .ratio(RATIO_DIV4),
        .out_tick(div4_tick)
    );

    // A programmed divide-by-eight fuse prescales the system clock by eight.
    assign prescale_ratio = (st.div8 == FUSE_PROGRAMMED) ? RATIO_DIV8 : RATIO_ONE;

    tick_divider prescaler (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_tick(st.src_tick),
        .ratio(prescale_ratio),
        .out_tick(sys_clk_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic: source routing, start-up sequencing and calibration.
    always_comb begin
        plan_s plan;
        plan = '0;
        next_st = st;

        // Pick the selected source tick; unsupported codes fall back to the 8 MHz RC.
        // The tick is registered, so RC and 128 kHz ticks reach the counters one cycle late, divided PLL and legacy ticks two.
        case (st.cks)
            SRC_PLL: next_st.src_tick = div4_tick;
            SRC_RC_LEGACY: next_st.src_tick = div4_tick;
            SRC_LP128K: next_st.src_tick = lp_tick;
            default: next_st.src_tick = rc_tick;
        endcase

        // The PLL runs for either fuse selection or on request from the timer side.
        next_st.pll_en = pll_enable_request || st.cks == SRC_PLL
                         || st.cks == SRC_RC_LEGACY;
        // Legacy mode trims the RC to 6.4 MHz and sets the PLL to four times.
        next_st.legacy = (st.cks == SRC_RC_LEGACY);
        next_st.pck = pll_tick && st.pll_en;
        // The watchdog keeps its own oscillator whatever the system source is.
        next_st.wdt_out = wdt_tick;

        case (st.phase)
            ST_LOAD: begin
                // Fuses are sampled once, here, so a later change has no effect.
                next_st.cks = clock_source_select;
                next_st.stc = startup_time_select;
                next_st.rdis = reset_pin_disable_fuse;
                next_st.div8 = initial_divide_by_eight_fuse;
                next_st.cal = factory_calibration;
                plan = startup_plan(clock_source_select, startup_time_select,
                                    reset_pin_disable_fuse, 1'b1);
                next_st.ck_left = plan.ck;
                next_st.ms_left = plan.ms;
                // Reserved start-up codes and sources outside this block are flagged.
                next_st.cfg_err = (startup_time_select == START_11
                                   && clock_source_select != SRC_PLL
                                   && clock_source_select != SRC_RC_LEGACY)
                                  || clock_source_select == 4'h0
                                  || clock_source_select > SRC_LP128K;
                next_st.run = 1'b0;
                next_st.phase = ST_MS;
            end
            ST_MS: begin
                // The real-time part runs first, on the watchdog oscillator.
                if (st.ms_left == 14'h0000) begin
                    next_st.phase = ST_CK;
                end else if (wdt_tick) begin
                    next_st.ms_left = st.ms_left - 14'h0001;
                end
            end
            ST_CK: begin
                // Cycles are counted on the newly selected source before code runs.
                if (st.ck_left == 15'h0000) begin
                    next_st.run = 1'b1;
                    next_st.phase = ST_RUN;
                end else if (st.src_tick) begin
                    next_st.ck_left = st.ck_left - 15'h0001;
                end
            end
            ST_RUN: begin
                if (sleep_request) begin
                    next_st.run = 1'b0;
                    next_st.phase = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // Wake from power-down uses the shorter wake plan.
                if (wake_request) begin
                    plan = startup_plan(st.cks, st.stc, st.rdis, 1'b0);
                    next_st.ck_left = plan.ck;
                    next_st.ms_left = plan.ms;
                    next_st.phase = ST_MS;
                end
            end
            default: begin
                next_st.run = 1'b0;
                next_st.phase = ST_LOAD;
            end
        endcase

        // Software trim wins over the stored value once the factory load is done.
        if (cal_write && st.phase != ST_LOAD) begin
            next_st.cal = cal_write_data;
        end
    end

    // Register the whole state; the reset returns to the fuse-load phase.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '{phase: ST_LOAD, cks: SRC_RESET, stc: START_RESET,
                    rdis: 1'b1, div8: FUSE_PROGRAMMED, ck_left: 15'h0000,
                    ms_left: 14'h0000, cal: CAL_RESET, default: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign cpu_run = st.run;
    assign peripheral_clk_tick = st.pck;
    assign wdt_clk_tick = st.wdt_out;
    assign pll_enable = st.pll_en;
    assign rc_legacy_mode = st.legacy;
    assign osc_calibration_value = st.cal;
    assign config_error = st.cfg_err;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the sequencing and the start-up plans.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_run_after_count: assert property ($rose(cpu_run) |-> $past(st.phase) == ST_CK
        && $past(st.ck_left) == 15'h0000)
        else $error("execution released before the cycle count ended");

    a_ms_before_ck: assert property (st.phase == ST_CK |-> st.ms_left == 14'h0000)
        else $error("cycle count started before the millisecond wait ended");

    a_ms_decrement: assert property (st.phase == ST_MS && st.ms_left != 14'h0000 && wdt_tick
        |=> st.ms_left == $past(st.ms_left) - 14'h0001)
        else $error("watchdog tick did not shorten the wait");

    a_cal_factory: assert property (st.phase == ST_LOAD
        |=> osc_calibration_value == $past(factory_calibration))
        else $error("factory calibration not loaded");

    a_cal_write: assert property (cal_write && st.phase != ST_LOAD
        |=> osc_calibration_value == $past(cal_write_data))
        else $error("software calibration write lost");

    a_wdt_follow: assert property (wdt_tick |=> wdt_clk_tick)
        else $error("watchdog tick not passed on");

    a_pll_selected: assert property (st.phase == ST_RUN && st.cks == SRC_PLL
        |-> pll_enable)
        else $error("PLL off while selected");

    a_legacy_mode: assert property (st.phase == ST_RUN && st.cks == SRC_RC_LEGACY
        |-> rc_legacy_mode && pll_enable)
        else $error("legacy mode not signalled");

    a_plan_pll: assert property (st.phase == ST_LOAD && clock_source_select == SRC_PLL
        && startup_time_select == START_01 |=> st.ck_left == WAKE_BASE_CK + 15'(LONG_CK)
        && st.ms_left == MS4_WDT + MS4_WDT)
        else $error("wrong PLL reset plan");

    a_plan_rc: assert property (st.phase == ST_LOAD && clock_source_select == SRC_RC8
        && startup_time_select == START_00 && reset_pin_disable_fuse
        |=> st.ck_left == RC_WAKE_CK + RESET_CK && st.ms_left == 14'h0000)
        else $error("wrong RC reset plan");

    a_plan_rdis: assert property (st.phase == ST_LOAD && clock_source_select == SRC_RC_LEGACY
        && startup_time_select == START_11 && !reset_pin_disable_fuse
        |=> st.ck_left == FAST_WAKE_CK + RESET_CK && st.ms_left == MS4_WDT)
        else $error("reset pin disable did not add the 4 ms wait");

    c_reach_run: cover property (st.phase == ST_CK ##1 cpu_run);
    c_sleep_wake: cover property (st.phase == ST_SLEEP && wake_request ##1 st.phase == ST_MS);
    c_cal_write: cover property (cpu_run && cal_write);
    c_legacy_run: cover property (cpu_run && rc_legacy_mode);

    // A sleep request while running must stop execution on the next edge.
    a_sleep_stop: assert property (st.phase == ST_RUN && sleep_request |=> !cpu_run)
        else $error("execution kept running after a sleep request");

    // Execution stays held for the whole of power-down.
    a_sleep_held: assert property (st.phase == ST_SLEEP |-> !cpu_run)
        else $error("execution allowed while asleep");

    // The fast peripheral tick only follows a fast tick while the PLL is on.
    a_pck_gated: assert property (peripheral_clk_tick |-> $past(pll_tick)
        && $past(pll_enable))
        else $error("peripheral tick without an enabled PLL tick");

    // The reserved start-up code of the RC source is flagged.
    a_reserved_flag: assert property (st.phase == ST_LOAD && clock_source_select == SRC_RC8
        && startup_time_select == START_11 |=> config_error)
        else $error("reserved start-up code not flagged");

endmodule

`default_nettype wire

// ==== testbench/clock_startup_select_bench.sv ====
`default_nettype none

module clock_startup_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import clock_startup_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////
    // Small counts keep every start-up short while the shape of each plan stays intact.
    localparam int LONG = 64;
    localparam int MS64 = 32;

    logic ref_clk = 1'b0; // The 100 MHz system clock.
    logic rst = 1'b1; // Synchronous reset, high while active.
    logic [3:0] clock_source_select = SRC_RC8;
    logic [1:0] startup_time_select = START_10;
    logic initial_divide_by_eight_fuse = FUSE_PROGRAMMED;
    logic reset_pin_disable_fuse = 1'b1;
    logic [7:0] factory_calibration = 8'h00;
    logic pll_tick = 1'b1; // The fast clock ticks on every cycle.
    logic rc_tick = 1'b1; // The RC oscillator ticks on every cycle.
    logic lp_tick = 1'b0; // The slow oscillator ticks on every third cycle.
    logic wdt_tick = 1'b0; // The watchdog oscillator ticks on every second cycle.
    logic pll_enable_request = 1'b0;
    logic cal_write = 1'b0;
    logic [7:0] cal_write_data = 8'h00;
    logic sleep_request = 1'b0;
    logic wake_request = 1'b0;
    logic cpu_run, sys_clk_tick, peripheral_clk_tick, wdt_clk_tick;
    logic pll_enable, rc_legacy_mode, config_error;
    logic [7:0] osc_calibration_value;
    int err_count = 0; // Mismatches seen so far.
    int checks = 0; // Comparisons made so far.
    int cyc = 0; // Free-running cycle count that paces the tick inputs.
    logic rst_at_edge = 1'b1; // Reset as the last rising edge saw it.
    logic pll_en_d = 1'b0; // The enable that gated the last fast tick.
    logic [7:0] cases [17] = '{8'h12, 8'h17, 8'h1a, 8'h1e, 8'h22, 8'h20, 8'h27, 8'h2a,
        8'h2e, 8'h32, 8'h36, 8'h3b, 8'h3e, 8'h3c, 8'h40, 8'h47, 8'h4a};

    clock_startup_select #(.LONG_CK(LONG), .MS64_WDT(MS64)) uut (
        .ref_clk(ref_clk), .rst(rst), .clock_source_select(clock_source_select),
        .startup_time_select(startup_time_select),
        .initial_divide_by_eight_fuse(initial_divide_by_eight_fuse),
        .reset_pin_disable_fuse(reset_pin_disable_fuse),
        .factory_calibration(factory_calibration), .pll_tick(pll_tick), .rc_tick(rc_tick),
        .lp_tick(lp_tick), .wdt_tick(wdt_tick), .pll_enable_request(pll_enable_request),
        .cal_write(cal_write), .cal_write_data(cal_write_data),
        .sleep_request(sleep_request), .wake_request(wake_request), .cpu_run(cpu_run),
        .sys_clk_tick(sys_clk_tick), .peripheral_clk_tick(peripheral_clk_tick),
        .wdt_clk_tick(wdt_clk_tick), .pll_enable(pll_enable),
        .rc_legacy_mode(rc_legacy_mode), .osc_calibration_value(osc_calibration_value),
        .config_error(config_error));

    ////////////////////////////////////////////////////////////////////////////////////
    // The clock toggles every half period of 5 ns.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // Reset is captured on the rising edge so the monitor never races the stimulus.
    always @(posedge ref_clk) begin
        rst_at_edge <= rst;
    end

    // The monitor checks the delayed tick outputs against the inputs held over the last
    // rising edge, then moves the oscillator ticks on; both happen on the falling edge.
    always @(negedge ref_clk) begin
        if (rst_at_edge === 1'b0) begin
            check({15'h0, wdt_clk_tick}, {15'h0, wdt_tick});
            check({15'h0, peripheral_clk_tick}, {15'h0, pll_tick & pll_en_d});
        end
        pll_en_d = pll_enable;
        cyc = cyc + 1;
        wdt_tick = cyc[0];
        lp_tick = (cyc % 3 == 0);
    end

    // A hang ends the run as a mismatch, well past the few tens of thousands of cycles
    // that the whole list of cases needs.
    initial begin
        #700_000;
        err_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // One comparison, counted, with a line printed on a mismatch.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the verdict and stops the simulation.
    task automatic close_out();
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Cycles from a start to execution: watchdog ticks at two cycles each, then source
    // ticks at the rate each source runs at here.
    function automatic int plan_len(input logic [3:0] cks, input logic [1:0] stc,
                                    input logic rdis, input bit boot);
        int ck, ms, rate;
        ms = 0;
        rate = 1;
        if (cks == SRC_PLL) begin
            ck = 14 + (stc[0] ? LONG : 1024);
            ms = (stc[1] ? MS64 : 512) + (boot ? 512 : 0);
            rate = 4;
        end else if (cks == SRC_RC_LEGACY) begin
            ck = (stc == START_11) ? 1 : 6;
            rate = 4;
            if (boot) begin
                ck += 14;
                ms = !stc[1] ? MS64 : (!stc[0] ? 512 : (rdis == FUSE_PROGRAMMED ? 512 : 0));
            end
        end else begin
            ck = 6;
            rate = (cks == SRC_LP128K) ? 3 : 1;
            if (boot) begin
                ck += 14;
                if (stc == START_00) begin
                    ms = (rdis == FUSE_PROGRAMMED) ? 512 : 0;
                end else begin
                    ms = (stc == START_01) ? 512 : MS64;
                end
            end
        end
        return 2 * ms + rate * ck;
    endfunction

    // Execution must stay held until just before the planned length and start soon after.
    task automatic measure(input int n);
        int i;
        repeat (n - 3) @(negedge ref_clk);
        check({15'h0, cpu_run}, 16'h0000);
        for (i = 0; i < 16 && cpu_run !== 1'b1; i++) @(negedge ref_clk);
        check({15'h0, cpu_run}, 16'h0001);
    endtask

    // One full pass for a fuse setting: reset start-up, checks while running, a refused
    // wake, sleep, and the wake start-up.
    task automatic run_case(input logic [7:0] c);
        logic [3:0] cks;
        logic [1:0] stc;
        int rate, cnt, e;
        cks = c[7:4];
        stc = c[3:2];
        rate = (cks == SRC_PLL || cks == SRC_RC_LEGACY) ? 4 : (cks == SRC_LP128K ? 3 : 1);
        clock_source_select = cks;
        startup_time_select = stc;
        reset_pin_disable_fuse = c[1];
        initial_divide_by_eight_fuse = c[0];
        factory_calibration = c ^ 8'h5a;
        rst = 1'b1;
        repeat (5) @(negedge ref_clk);
        check({8'h0, osc_calibration_value}, 16'h0000);
        check({15'h0, cpu_run}, 16'h0000);
        rst = 1'b0;
        measure(plan_len(cks, stc, c[1], 1'b1));
        check({8'h0, osc_calibration_value}, {8'h0, c ^ 8'h5a});
        e = (cks == SRC_PLL || cks == SRC_RC_LEGACY) ? 1 : 0;
        check({15'h0, pll_enable}, e[15:0]);
        check({15'h0, rc_legacy_mode}, {15'h0, cks == SRC_RC_LEGACY});
        e = (stc == START_11 && cks != SRC_PLL && cks != SRC_RC_LEGACY) ? 1 : 0;
        check({15'h0, config_error}, e[15:0]);
        // The prescaled tick is counted over a window with one tick of slack either way.
        cnt = 0;
        repeat (96) begin
            @(negedge ref_clk);
            cnt += (sys_clk_tick === 1'b1) ? 1 : 0;
        end
        e = 96 / (rate * (c[0] == FUSE_PROGRAMMED ? 8 : 1));
        check({15'h0, cnt >= e - 1 && cnt <= e + 1}, 16'h0001);
        pll_enable_request = 1'b1;
        cal_write = 1'b1;
        cal_write_data = ~c;
        @(negedge ref_clk);
        cal_write = 1'b0;
        check({8'h0, osc_calibration_value}, {8'h0, ~c});
        @(negedge ref_clk);
        check({15'h0, pll_enable}, 16'h0001);
        pll_enable_request = 1'b0;
        wake_request = 1'b1;
        @(negedge ref_clk);
        wake_request = 1'b0;
        repeat (2) @(negedge ref_clk);
        check({15'h0, cpu_run}, 16'h0001);
        sleep_request = 1'b1;
        @(negedge ref_clk);
        sleep_request = 1'b0;
        check({15'h0, cpu_run}, 16'h0000);
        repeat (3) @(negedge ref_clk);
        wake_request = 1'b1;
        @(negedge ref_clk);
        wake_request = 1'b0;
        measure(plan_len(cks, stc, c[1], 1'b0) - 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    // Each of the four source codes is run, with every start-up code except 11 on the 128 kHz source,
    // both reset-pin settings where they matter except on the 128 kHz source, and both settings
    // of the divide-by-eight fuse.
    initial begin
        repeat (5) @(negedge ref_clk);
        foreach (cases[k]) begin
            run_case(cases[k]);
        end
        close_out();
    end

endmodule

`default_nettype wire
